// ===== shared/afi_pkg.sv
// Package with register map, command codes, identify constants and carrier types
package afi_pkg;

  // Task-file register indices (byte address is four times the index)
  localparam logic [3:0]  IDX_FEATURE_PARAM    = 4'h1;
  localparam logic [3:0]  IDX_SECTOR_TALLY     = 4'h2;
  localparam logic [3:0]  IDX_SECTOR_INDEX     = 4'h3;
  localparam logic [3:0]  IDX_CYLINDER_LOWER   = 4'h4;
  localparam logic [3:0]  IDX_CYLINDER_UPPER   = 4'h5;
  localparam logic [3:0]  IDX_UNIT_SELECT_HEAD = 4'h6;
  localparam logic [3:0]  IDX_COMMAND_CODE     = 4'h7;
  // Added registers: status, data port, capacity, multiple setting, fill status
  localparam logic [3:0]  IDX_STATUS           = 4'h8;
  localparam logic [3:0]  IDX_DATA_PORT        = 4'h9;
  localparam logic [3:0]  IDX_CAPACITY         = 4'hA;
  localparam logic [3:0]  IDX_MULTI_SETTING    = 4'hB;
  localparam logic [3:0]  IDX_FILL_STATUS      = 4'hC;

  // Command codes
  localparam logic [7:0]  CMD_ERASE_SECTORS    = 8'hC0;
  localparam logic [7:0]  CMD_FORMAT_TRACK     = 8'h50;
  localparam logic [7:0]  CMD_IDENTIFY         = 8'hEC;

  // Status bit positions, plus LBA_BIT of the unit select/head register
  localparam int          STAT_BUSY_BIT        = 7;
  localparam int          STAT_DRQ_BIT         = 3;
  localparam int          STAT_ERR_BIT         = 0;
  localparam int          LBA_BIT              = 6;

  // Fill pattern for format track
  localparam logic [7:0]  FORMAT_FILL_BYTE     = 8'hFF;

  // Identify block constants
  localparam logic [8:0]  ID_WORDS             = 9'h100;
  localparam logic [7:0]  SECTOR_WORDS_LAST    = 8'hFF;
  localparam logic [15:0] ID_GEN_CONFIG        = 16'h848A;
  localparam logic [15:0] ID_BYTES_PER_SECTOR  = 16'h0240;
  localparam logic [15:0] ID_BUFFER_TYPE       = 16'h0002;
  localparam logic [15:0] ID_BUFFER_SIZE       = 16'h0002;
  localparam logic [15:0] ID_ECC_BYTES         = 16'h0004;
  localparam logic [15:0] ID_MULTI_MAX         = 16'h0001;
  localparam logic [15:0] ID_DWORD_IO          = 16'h0000;
  localparam logic [15:0] ID_CAPABILITIES      = 16'h0200;
  localparam logic [15:0] ID_PIO_MODE          = 16'h0100;
  localparam logic [15:0] ID_DMA_MODE          = 16'h0000;
  localparam logic [15:0] ID_XLATE_VALID       = 16'h0001;
  localparam logic [7:0]  ID_MULTI_VALID_BYTE  = 8'h01;
  localparam logic [7:0]  ASCII_SPACE          = 8'h20;

  // Default geometry after reset (plain values)
  localparam logic [15:0] RST_CYLINDERS        = 16'h0100;
  localparam logic [15:0] RST_HEADS            = 16'h0004;
  localparam logic [15:0] RST_SECTORS_TRACK    = 16'h0020;
  localparam logic [31:0] RST_CAPACITY         = 32'h0000_8000;

  // Timing: busy within 400 ns, DRQ within 700 us of the command
  localparam int          CLK_PERIOD_NS        = 50;
  localparam int          BUSY_SET_NS          = 400;
  localparam int          DRQ_RAISE_US         = 700;
  localparam int          BUSY_SET_CYC         = BUSY_SET_NS / CLK_PERIOD_NS;
  localparam int          DRQ_RAISE_CYC        = (DRQ_RAISE_US * 1000) / CLK_PERIOD_NS;
  localparam logic [3:0]  CMD_SETUP_CYC        = 4'h4;

  // Fill engine request carrier
  typedef struct packed {
    logic [31:0] start_lba;
    logic [8:0]  count;
  } afi_fill_req_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_DATAIN = 3'b011,
    ST_FILL   = 3'b010,
    ST_DATAOUT= 3'b110,
    ST_ERASE  = 3'b111
  } afi_state_type;

endpackage : afi_pkg

// ===== hw/afi_fill.sv
// Sector fill engine that writes a constant byte over a run of sectors
`timescale 1ns/1ps
`default_nettype none
module afi_fill
  import afi_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             start,
  input  wire afi_fill_req_type req,
  input  wire logic [7:0]       pattern,
  output logic                  busy,
  output logic                  wr_valid,
  output logic [31:0]           wr_lba,
  output logic [7:0]            wr_byte,
  output logic                  done
);

  logic [8:0]  left_reg;
  logic [7:0]  word_reg;
  logic [31:0] lba_reg;

  // One sector per 256 word slots; pattern is constant so bytes are not tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      left_reg <= 9'h000;
      word_reg <= 8'h00;
      wr_lba   <= 32'h0000_0000;
      lba_reg  <= 32'h0000_0000;
      wr_valid <= 1'b0;
      wr_byte  <= 8'h00;
      done     <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (!busy) begin
        wr_valid <= 1'b0;
        if (start && req.count != 9'h000) begin
          busy     <= 1'b1;
          left_reg <= req.count;
          lba_reg  <= req.start_lba;
          word_reg <= 8'h00;
        end else if (start) begin
          done <= 1'b1;
        end
      end else begin
        wr_valid <= 1'b1;
        wr_byte  <= pattern;
        wr_lba   <= lba_reg; // Address leaves with its word, before the step
        word_reg <= word_reg + 8'h01;
        if (word_reg == SECTOR_WORDS_LAST) begin
          lba_reg  <= lba_reg + 32'h0000_0001;
          left_reg <= left_reg - 9'h001;
          if (left_reg == 9'h001) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule : afi_fill
`default_nettype wire

// ===== hw/afi_cmd.sv
// Task-file command interpreter for erase, format track and identify drive
//
// Overview of operation
// - Accept erase sectors C0H for compatibility
// - Format track fills addressed track with FFh
// - Format track takes one sector, discards it
// - LBA format count from sector tally, 0=256
// - Identify returns block like read sector
// - Reserved identify bits and words read zero
// - Word 0 holds 848AH
// - Word 5 holds 0240H
// - Words 7-8 total sectors, MSW first
// - Capacity is first invalid LBA
// - Serial words right justified, space padded
// - Word 20 holds 0002H
// - Word 21 holds 0002H buffer size
// - Word 22 holds 0004H ECC bytes
// - Words 23-26 firmware ASCII, big-endian
// - Words 27-46 model, left justified, spaces
// - Word 47 holds 0001H
// - Word 48 holds 0000H
// - Word 49 holds 0200H
// - Word 51 0100H, word 52 zero
// - Words 57-58 capacity, LSW first
// - Word 59 is 01h plus setting
// - Format DRQ within 700 us, busy clears
// - Busy within 400 ns of command
`timescale 1ns/1ps
`default_nettype none
module afi_cmd
  import afi_pkg::*;
#(
  parameter logic [15:0] SERIAL_TAIL = 16'h3031, // Arbitrary serial digits
  parameter logic [15:0] FW_REV      = 16'h3130, // Arbitrary revision text
  parameter logic [15:0] MODEL_HEAD  = 16'h4344  // Arbitrary model text
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             busy_out,
  output logic             drq_out,
  output logic             media_wr_valid,
  output logic [31:0]      media_wr_lba,
  output logic [7:0]       media_wr_byte,
  output logic             media_erase_pulse
);

  // Task-file registers
  logic [7:0]       feature_param_reg;
  logic [7:0]       sector_tally_reg;
  logic [7:0]       sector_index_reg;
  logic [7:0]       cylinder_lower_reg;
  logic [7:0]       cylinder_upper_reg;
  logic [7:0]       unit_select_head_reg;
  logic [7:0]       command_reg;
  logic [31:0]      capacity_reg;
  logic [7:0]       multi_setting_reg;

  // Sequencer and fill hand-off
  logic             err_reg;
  afi_state_type    state_reg;
  logic [8:0]       word_cnt_reg;
  logic [3:0]       setup_cnt_reg;
  logic             fill_start_reg;
  afi_fill_req_type fill_req;
  logic             fill_busy;
  logic             fill_done;

  // Bus decode
  logic [15:0]      id_word;
  logic [3:0]       reg_idx;
  logic             access;
  logic             cmd_write;
  logic             data_read;
  logic             data_write;
  logic [31:0]      rd_next;
  logic             addr_ok;
  logic [27:0]      lba_addr;

  // A request is taken in its wait state, while pready is low, so a held
  // access is taken again every second cycle while the master keeps it up
  assign reg_idx    = paddr[5:2];
  assign access     = psel && penable;
  assign addr_ok    = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'b00)
                      && (reg_idx >= IDX_FEATURE_PARAM) && (reg_idx <= IDX_FILL_STATUS);
  assign cmd_write  = access && pwrite && addr_ok && reg_idx == IDX_COMMAND_CODE
                      && !pready && state_reg == ST_IDLE;
  // Data-port strobes; the sequencer decides whether they count
  assign data_read  = access && !pwrite && addr_ok && reg_idx == IDX_DATA_PORT && !pready;
  assign data_write = access && pwrite && addr_ok && reg_idx == IDX_DATA_PORT && !pready;

  // Block address: head nibble, cylinder bytes, sector index
  assign lba_addr   = {unit_select_head_reg[3:0], cylinder_upper_reg,
                       cylinder_lower_reg, sector_index_reg};

  // APB answer: one wait state, then pready for one cycle
  // Read data and the error flag stand only while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      prdata  <= (access && !pready && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // Task-file parameter registers
  // Capacity is writable so a smaller card can be modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_param_reg    <= 8'h00;
      sector_tally_reg     <= 8'h00;
      sector_index_reg     <= 8'h00;
      cylinder_lower_reg   <= 8'h00;
      cylinder_upper_reg   <= 8'h00;
      unit_select_head_reg <= 8'h00;
      capacity_reg         <= RST_CAPACITY;
      multi_setting_reg    <= 8'h00;
    end else if (clk_en && access && pwrite && addr_ok && !pready && state_reg == ST_IDLE) begin
      case (reg_idx)
        IDX_FEATURE_PARAM:    feature_param_reg    <= pwdata[7:0];
        IDX_SECTOR_TALLY:     sector_tally_reg     <= pwdata[7:0];
        IDX_SECTOR_INDEX:     sector_index_reg     <= pwdata[7:0];
        IDX_CYLINDER_LOWER:   cylinder_lower_reg   <= pwdata[7:0];
        IDX_CYLINDER_UPPER:   cylinder_upper_reg   <= pwdata[7:0];
        IDX_UNIT_SELECT_HEAD: unit_select_head_reg <= pwdata[7:0];
        IDX_CAPACITY:         capacity_reg         <= pwdata;
        // Only 00h and 01h are legal settings; others fold to bit 0
        IDX_MULTI_SETTING:    multi_setting_reg    <= {7'h00, pwdata[0]};
        default: ;
      endcase
    end
  end

  // Register read mux; the command register is write only
  // The data port reads zero outside an identify, never a stale word
  always_comb begin
    rd_next = 32'h0000_0000;
    case (reg_idx)
      IDX_FEATURE_PARAM:    rd_next = {24'h0, feature_param_reg};
      IDX_SECTOR_TALLY:     rd_next = {24'h0, sector_tally_reg};
      IDX_SECTOR_INDEX:     rd_next = {24'h0, sector_index_reg};
      IDX_CYLINDER_LOWER:   rd_next = {24'h0, cylinder_lower_reg};
      IDX_CYLINDER_UPPER:   rd_next = {24'h0, cylinder_upper_reg};
      IDX_UNIT_SELECT_HEAD: rd_next = {24'h0, unit_select_head_reg};
      IDX_STATUS:           rd_next = {24'h0, busy_out, 3'b000, drq_out, 2'b00, err_reg};
      IDX_DATA_PORT:        rd_next = (state_reg == ST_DATAOUT) ? {16'h0, id_word} : 32'h0;
      IDX_CAPACITY:         rd_next = capacity_reg;
      IDX_MULTI_SETTING:    rd_next = {24'h0, multi_setting_reg};
      IDX_FILL_STATUS:      rd_next = {31'h0, fill_busy};
      default:              rd_next = 32'h0000_0000;
    endcase
  end

  // Identify block word generator; anything not listed or space padded reads zero
  // Geometry words echo the fixed reset geometry; there is no translation
  // Only the low byte of the counter addresses a word
  always_comb begin
    id_word = 16'h0000;
    case (word_cnt_reg[7:0])
      8'd0:  id_word = ID_GEN_CONFIG;
      8'd1:  id_word = RST_CYLINDERS;
      8'd3:  id_word = RST_HEADS;
      8'd5:  id_word = ID_BYTES_PER_SECTOR;
      8'd6:  id_word = RST_SECTORS_TRACK;
      8'd7:  id_word = capacity_reg[31:16];
      8'd8:  id_word = capacity_reg[15:0];
      8'd19: id_word = SERIAL_TAIL;
      8'd20: id_word = ID_BUFFER_TYPE;
      8'd21: id_word = ID_BUFFER_SIZE;
      8'd22: id_word = ID_ECC_BYTES;
      8'd23: id_word = FW_REV;
      8'd27: id_word = MODEL_HEAD;
      8'd47: id_word = ID_MULTI_MAX;
      8'd48: id_word = ID_DWORD_IO;
      8'd49: id_word = ID_CAPABILITIES;
      8'd51: id_word = ID_PIO_MODE;
      8'd52: id_word = ID_DMA_MODE;
      8'd53: id_word = ID_XLATE_VALID;
      8'd54: id_word = RST_CYLINDERS;
      8'd55: id_word = RST_HEADS;
      8'd56: id_word = RST_SECTORS_TRACK;
      8'd57: id_word = capacity_reg[15:0];
      8'd58: id_word = capacity_reg[31:16];
      8'd59: id_word = {ID_MULTI_VALID_BYTE, multi_setting_reg};
      8'd60: id_word = capacity_reg[15:0];
      8'd61: id_word = capacity_reg[31:16];
      default: begin
        // Padding with spaces: serial leads, firmware and model trail
        if (word_cnt_reg[7:0] >= 8'd10 && word_cnt_reg[7:0] <= 8'd18) begin
          id_word = {ASCII_SPACE, ASCII_SPACE};
        end else if (word_cnt_reg[7:0] >= 8'd24 && word_cnt_reg[7:0] <= 8'd46) begin
          id_word = {ASCII_SPACE, ASCII_SPACE};
        end
      end
    endcase
  end

  // Command sequencer; busy is raised the cycle after the code is written
  // Every exit from a busy state drops busy, so a refused command never hangs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      busy_out       <= 1'b0;
      drq_out        <= 1'b0;
      err_reg        <= 1'b0;
      command_reg    <= 8'h00;
      word_cnt_reg   <= 9'h000;
      setup_cnt_reg  <= 4'h0;
      fill_start_reg <= 1'b0;
      fill_req       <= '0;
      media_erase_pulse <= 1'b0;
    end else if (clk_en) begin
      fill_start_reg    <= 1'b0;
      media_erase_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // A code written while busy is dropped; the host polls first
          if (cmd_write) begin
            command_reg   <= pwdata[7:0];
            busy_out      <= 1'b1;
            err_reg       <= 1'b0;
            setup_cnt_reg <= CMD_SETUP_CYC;
            word_cnt_reg  <= 9'h000;
            state_reg     <= ST_SETUP;
          end
        end

        ST_SETUP: begin
          // Short buffer setup, far inside the 700 us window
          setup_cnt_reg <= setup_cnt_reg - 4'h1;
          if (setup_cnt_reg == 4'h1) begin
            case (command_reg)
              CMD_FORMAT_TRACK: begin
                drq_out   <= 1'b1;
                busy_out  <= 1'b0;
                state_reg <= ST_DATAIN;
              end
              CMD_IDENTIFY: begin
                drq_out   <= 1'b1;
                busy_out  <= 1'b0;
                state_reg <= ST_DATAOUT;
              end
              CMD_ERASE_SECTORS: begin
                if ({4'h0, lba_addr} >= capacity_reg) begin
                  // Out of range: flagged, nothing reaches the media
                  err_reg   <= 1'b1;
                  busy_out  <= 1'b0;
                  state_reg <= ST_IDLE;
                end else begin
                  // Erase kept only for old hosts; media engine does the work
                  media_erase_pulse <= 1'b1;
                  busy_out  <= 1'b0;
                  state_reg <= ST_IDLE;
                end
              end
              default: begin
                // Other commands belong elsewhere and are refused
                err_reg   <= 1'b1;
                busy_out  <= 1'b0;
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end

        ST_DATAIN: begin
          // Host sector is counted and dropped, never stored
          if (data_write) begin
            word_cnt_reg <= word_cnt_reg + 9'h001;
            if (word_cnt_reg == ID_WORDS - 9'h001) begin
              drq_out   <= 1'b0;
              busy_out  <= 1'b1;
              if (unit_select_head_reg[LBA_BIT]) begin
                // LBA mode starts at the block and runs for the tally
                fill_req.start_lba <= {4'h0, lba_addr};
                fill_req.count <= (sector_tally_reg == 8'h00) ? 9'h100
                                  : {1'b0, sector_tally_reg};
              end else begin
                // CHS mode refills the whole track from sector zero
                fill_req.start_lba <= {4'h0, lba_addr[27:8], 8'h00};
                fill_req.count     <= {1'b0, RST_SECTORS_TRACK[7:0]};
              end
              fill_start_reg <= 1'b1;
              state_reg <= ST_FILL;
            end
          end
        end

        ST_FILL: begin
          // Busy stays up for the whole fill; status polling sees it
          if (fill_done) begin
            busy_out  <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end

        ST_DATAOUT: begin
          // The word counter is also the identify word address
          if (data_read) begin
            word_cnt_reg <= word_cnt_reg + 9'h001;
            if (word_cnt_reg == ID_WORDS - 9'h001) begin
              drq_out   <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end

        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fill engine writes FFh over the selected sectors
  // It shares the clock enable, so a freeze stalls the fill as well
  afi_fill u_fill (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .start    (fill_start_reg),
    .req      (fill_req),
    .pattern  (FORMAT_FILL_BYTE),
    .busy     (fill_busy),
    .wr_valid (media_wr_valid),
    .wr_lba   (media_wr_lba),
    .wr_byte  (media_wr_byte),
    .done     (fill_done)
  );

endmodule : afi_cmd
`default_nettype wire

// ===== verification/afi_cmd_checker.sv
// Port-level assertion checker for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module afi_cmd_checker
  import afi_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy_out,
  input wire logic        drq_out,
  input wire logic        media_wr_valid,
  input wire logic [7:0]  media_wr_byte,
  input wire logic        media_erase_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        take;
  logic        cmd_wr;
  logic        fmt_wait;
  logic [15:0] wait_cnt;

  // Accepted bus access and an accepted command write while idle
  assign take   = psel && penable && !pready;
  assign cmd_wr = take && pwrite && paddr == {26'h0, IDX_COMMAND_CODE, 2'h0} && !busy_out
                  && !drq_out;

  // Cycles spent between a format command and its data request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_wait <= 1'b0;
      wait_cnt <= 16'h0;
    end else begin
      if (cmd_wr && pwdata[7:0] == CMD_FORMAT_TRACK) fmt_wait <= 1'b1;
      else if (drq_out) fmt_wait <= 1'b0;
      wait_cnt <= fmt_wait ? wait_cnt + 16'h1 : 16'h0;
    end
  end

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_wait_a: assert property (take |=> pready) else $error("access not answered next cycle");
  ready_cause_a: assert property (pready |-> $past(take)) else $error("pready without access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (take && (paddr[1:0] != 2'h0 || paddr < 32'h4 || paddr > 32'h30)
    |=> pslverr) else $error("unmapped access not refused");
  busy_rise_a: assert property (cmd_wr && (pwdata[7:0] == CMD_IDENTIFY
    || pwdata[7:0] == CMD_ERASE_SECTORS) |-> ##[1:8] busy_out)
    else $error("busy late after command");
  busy_clear_a: assert property ($rose(drq_out) |-> ##[0:8] !busy_out)
    else $error("busy not cleared after drq");
  drq_late_a: assert property (wait_cnt <= DRQ_RAISE_CYC)
    else $error("format drq too late");
  fill_byte_a: assert property (media_wr_valid |-> media_wr_byte == 8'hFF)
    else $error("fill byte wrong");
  erase_once_a: assert property (media_erase_pulse |=> !media_erase_pulse)
    else $error("erase pulse too long");
endmodule : afi_cmd_checker

bind afi_cmd afi_cmd_checker chk (.*);
`default_nettype wire

// ===== verification/afi_host.sv
// Host controller model: APB master issuing task-file accesses
`timescale 1ns/1ps
`default_nettype none
module afi_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata
);
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end

  // One transfer; released lines show the inverse so stale values never look valid
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : afi_host
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import afi_pkg::*;
;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic        busy_out, drq_out, media_wr_valid, media_erase_pulse;
  logic [31:0] paddr, pwdata, prdata, media_wr_lba, got, fill_cnt, lba_lo, lba_hi;
  logic [7:0]  media_wr_byte;
  int          err_count, checks, pulse_cnt;

  afi_cmd  dut (.*);
  afi_host host (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Fill and erase activity seen on the media side
  always @(posedge pclk) begin
    if (media_wr_valid === 1'b1) begin
      fill_cnt = fill_cnt + 1;
      if (media_wr_lba < lba_lo) lba_lo = media_wr_lba;
      if (media_wr_lba > lba_hi) lba_hi = media_wr_lba;
    end
    if (media_erase_pulse === 1'b1) pulse_cnt++;
  end

  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task wr(input logic [3:0] i, input logic [31:0] d);
    host.xfer(1'b1, {26'h0, i, 2'h0}, d, got, e);
  endtask : wr

  task rd(input logic [3:0] i);
    host.xfer(1'b0, {26'h0, i, 2'h0}, 32'h0, got, e);
  endtask : rd

  // Bounded wait for a given drq and busy pair
  task wait_st(input logic d, input logic b);
    int n;
    n = 0;
    while ((drq_out !== d || busy_out !== b) && n < 70000) begin
      @(posedge pclk);
      n++;
    end
    check("status wait", {31'h0, n < 70000}, 32'h1);
  endtask : wait_st

  // Expected identify word; bit 16 marks a word with a fixed value
  function automatic logic [16:0] id_word(input int w, input logic [31:0] cap);
    case (w) inside
      0: return {1'b1, 16'h848A};
      1, 54: return {1'b1, RST_CYLINDERS};
      3, 55: return {1'b1, RST_HEADS};
      6, 56: return {1'b1, RST_SECTORS_TRACK};
      5: return {1'b1, 16'h0240};
      7, 58: return {1'b1, cap[31:16]};
      8, 57: return {1'b1, cap[15:0]};
      [10:18], [28:46]: return {1'b1, 16'h2020};
      20, 21: return {1'b1, 16'h0002};
      22: return {1'b1, 16'h0004};
      47, 53: return {1'b1, 16'h0001};
      49: return {1'b1, 16'h0200};
      51: return {1'b1, 16'h0100};
      59: return {1'b1, 16'h0101};
      2, 4, 9, 48, 50, 52, [62:255]: return {1'b1, 16'h0000};
      default: return 17'h0;
    endcase
  endfunction : id_word

  task fmt(input logic [7:0] cnt, input logic [7:0] cyl, input logic l);
    logic [31:0] n;
    n = !l ? {16'h0, RST_SECTORS_TRACK} : (cnt == 8'h0) ? 32'h100 : {24'h0, cnt};
    wr(IDX_SECTOR_TALLY, {24'h0, cnt});
    wr(IDX_SECTOR_INDEX, 32'h0);
    wr(IDX_CYLINDER_LOWER, {24'h0, cyl});
    wr(IDX_CYLINDER_UPPER, 32'h0);
    wr(IDX_UNIT_SELECT_HEAD, l ? 32'hE0 : 32'hA0);
    fill_cnt = 32'h0;
    lba_lo = 32'hFFFFFFFF;
    lba_hi = 32'h0;
    wr(IDX_COMMAND_CODE, {24'h0, CMD_FORMAT_TRACK});
    wait_st(1'b1, 1'b0);
    repeat (256) wr(IDX_DATA_PORT, $urandom & 32'hFFFF);
    wait_st(1'b0, 1'b1);
    wait_st(1'b0, 1'b0);
    check("fill cycles", fill_cnt, n * 256);
    check("fill first lba", lba_lo, {16'h0, cyl, 8'h0});
    check("fill last lba", lba_hi, {16'h0, cyl, 8'h0} + n - 1);
  endtask : fmt

  task ers(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] sn, input logic ok);
    int p;
    wr(IDX_SECTOR_TALLY, 32'h1);
    wr(IDX_SECTOR_INDEX, {24'h0, sn});
    wr(IDX_CYLINDER_LOWER, {24'h0, lo});
    wr(IDX_CYLINDER_UPPER, {24'h0, hi});
    wr(IDX_UNIT_SELECT_HEAD, 32'hE0);
    p = pulse_cnt;
    wr(IDX_COMMAND_CODE, {24'h0, CMD_ERASE_SECTORS});
    repeat (8) @(posedge pclk);
    wait_st(1'b0, 1'b0);
    rd(IDX_STATUS);
    check("erase error bit", {31'h0, got[STAT_ERR_BIT]}, {31'h0, !ok});
    check("erase pulses", pulse_cnt - p, {31'h0, ok});
  endtask : ers

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    end_of_test;
  end

  initial begin
    logic [31:0] v;
    logic [16:0] x;
    presetn = 1'b0;
    clk_en = 1'b1;
    err_count = 0;
    checks = 0;
    pulse_cnt = 0;
    fill_cnt = 32'h0;
    v = $urandom(32'h4d4a);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Task-file registers hold what was written; unmapped places are refused
    for (int i = 1; i < 7; i++) begin
      v = $urandom;
      wr(i[3:0], v);
      rd(i[3:0]);
      check("task-file reg", got & 32'hFF, v & 32'hFF);
    end
    foreach (x[i]) if (i < 3) begin
      host.xfer(i[0], (i == 0) ? 32'h0 : (i == 1) ? 32'h5 : 32'h34, 32'h0, got, e);
      check("unmapped refusal", {31'h0, e}, 32'h1);
    end
    $display("test registers done");
    // Identify block, word by word, through the data port
    rd(IDX_CAPACITY);
    check("capacity reset", got, RST_CAPACITY);
    wr(IDX_MULTI_SETTING, 32'h1);
    wr(IDX_COMMAND_CODE, {24'h0, CMD_IDENTIFY});
    // Clock enable low must freeze the setup count
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    check("frozen status", {30'h0, drq_out, busy_out}, 32'h1);
    clk_en <= 1'b1;
    wait_st(1'b1, 1'b0);
    for (int i = 0; i < 256; i++) begin
      rd(IDX_DATA_PORT);
      x = id_word(i, RST_CAPACITY);
      if (x[16]) check($sformatf("identify word %0d", i), {16'h0, got[15:0]}, {16'h0, x[15:0]});
    end
    repeat (2) @(posedge pclk);
    check("drq after block", {31'h0, drq_out}, 32'h0);
    $display("test identify done");
    // Format at the top boundary with count zero, a short random run, a CHS track
    fmt(8'h00, 8'h7F, 1'b1);
    fmt(8'($urandom_range(1, 4)), 8'($urandom_range(0, 8'h6F)), 1'b1);
    fmt(8'($urandom), 8'h20, 1'b0);
    $display("test format done");
    // Erase inside capacity, at its last sector and at or beyond the limit
    ers(8'h00, 8'($urandom_range(0, 8'h7E)), 8'($urandom), 1'b1);
    ers(8'h00, 8'h7F, 8'hFF, 1'b1);
    ers(8'h00, 8'h80, 8'h00, 1'b0);
    ers(8'h01, 8'h00, 8'h00, 1'b0);
    $display("test erase done");
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
